/* common/dpm_pkg.sv */
// package: register map, field positions, reset values and state types of the power mux control
package dpm_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses, one aligned word each)
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_PATH = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h008;

  // control word fields
  localparam int unsigned CTRL_GDIS_BIT = 0;
  localparam int unsigned CTRL_BOTH_BIT = 1;
  localparam int unsigned CTRL_HIZ_BIT = 2;
  // path word fields
  localparam int unsigned PATH_EN2_BIT = 6;
  localparam int unsigned PATH_EN1_BIT = 7;
  // status word fields
  localparam int unsigned STAT_GD1_BIT = 0;
  localparam int unsigned STAT_GD2_BIT = 1;
  localparam int unsigned STAT_FIT1_BIT = 2;
  localparam int unsigned STAT_FIT2_BIT = 3;
  localparam int unsigned STAT_CHG_BIT = 4;
  localparam int unsigned STAT_VALID1_BIT = 5;
  localparam int unsigned STAT_VALID2_BIT = 6;

  ////////////////////////////////////////////////////////////////////////////////
  // state types
  typedef enum logic [1:0] {ST_DETECT, ST_OPEN, ST_CHANGE, ST_CLOSED} dpm_state_t;

  typedef struct packed {
    dpm_state_t st;
    logic gdis;
    logic both_dis;
    logic hiz;
    logic en1;
    logic en2;
    logic gd1;
    logic gd2;
    logic conv_stop;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dpm_core_t;

  typedef struct packed {
    logic done;
    logic fit1;
    logic fit2;
  } dpm_det_t;

  typedef struct packed {
    logic v1;
    logic v2;
    logic p1;
    logic p2;
    logic bus;
    logic oc;
  } dpm_qual_t;

  ////////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam dpm_core_t CORE_RST = '{st: ST_DETECT, gdis: 1'b0, both_dis: 1'b0, hiz: 1'b0,
                                     en1: 1'b0, en2: 1'b0, gd1: 1'b0, gd2: 1'b0,
                                     conv_stop: 1'b0, pready: 1'b0, pslverr: 1'b0,
                                     prdata: 32'h0000_0000};
  localparam dpm_det_t DET_RST = '{done: 1'b0, fit1: 1'b0, fit2: 1'b0};
  localparam dpm_qual_t QUAL_RST = '{v1: 1'b0, v2: 1'b0, p1: 1'b0, p2: 1'b0, bus: 1'b0, oc: 1'b0};

endpackage

/* common/dpm_sense_if.sv */
// interface: fitted pairs and qualified source conditions passed to the mux core
`timescale 1ns/10ps
interface dpm_sense_if;
  logic fit1;
  logic fit2;
  logic det_done;
  logic valid1;
  logic valid2;
  logic rise1;
  logic rise2;
  logic bus_present;
  logic bus_oc;
  modport det (output fit1, output fit2, output det_done);
  modport qual (output valid1, output valid2, output rise1, output rise2,
                output bus_present, output bus_oc);
  modport core (input fit1, input fit2, input det_done, input valid1, input valid2,
                input rise1, input rise2, input bus_present, input bus_oc);
endinterface

/* hdl/dpm_detect.sv */
// module: one-shot detection of fitted switch pairs after reset release
`timescale 1ns/10ps
module dpm_detect (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // gate drive short sense
  input wire logic gate_drive_one_short_i,
  input wire logic gate_drive_two_short_i,
  // results
  dpm_sense_if.det sense
);
  import dpm_pkg::*;

  dpm_det_t s;
  dpm_det_t n;

  // the pins are sampled on the first edge after release, drives still off
  always_comb begin
    n = s;
    if (!s.done) begin
      n.done = 1'b1;
      n.fit1 = ~gate_drive_one_short_i;
      n.fit2 = ~gate_drive_two_short_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      s <= DET_RST;
    end else begin
      s <= n;
    end
  end

  assign sense.fit1 = s.fit1;
  assign sense.fit2 = s.fit2;
  assign sense.det_done = s.done;
endmodule // dpm_detect

/* hdl/dpm_power_mux.sv */
// module: dual input power mux control with apb registers
// Operation
// - both drives shorted at reset: no pairs, statuses 0, global disable 1, enables locked 0.
// - only drive one free: only pair one fitted, second status 0, enable two locked 0.
// - both pairs fitted at reset: both presence status bits read 1.
// - path status reads 0 when pair open, 1 when pair closed.
// - global disable 1 forces all drives off; 0 allows drives when conditions hold.
// - path enable 0 forces its drive off; 1 turns on only if conditions hold.
// - one pair fitted: valid source one sets enable one and closes pair one.
// - both pairs fitted: first source to become valid gets its pair closed.
// - simultaneous valid sources: path one wins, enable one set, pair two open.
// - second source appearing while first path is active keeps pair two open.
// - host may swap paths by exchanging both enable bits in one write.
// - host write setting both enables to 1 is ignored when both pairs are fitted.
// - path change opens old pair, waits bus below present, then closes new.
// - both valid and active source fails: device swaps to the other source.
// - autonomous swaps update both enable bits to show the active path.
// - writing 00 with only one valid source does not open both pairs.
// - both sources valid: 00 write or global disable opens both pairs.
// - drive turns on only if fitted, source valid, no blocks, bus low.
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/10ps
module dpm_power_mux (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // apb slave
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // gate drive short sense
  input wire logic gate_drive_one_short_i,
  input wire logic gate_drive_two_short_i,
  // source and bus comparators
  input wire logic source_one_present_i,
  input wire logic source_one_overvoltage_i,
  input wire logic source_one_undervoltage_i,
  input wire logic source_two_present_i,
  input wire logic source_two_overvoltage_i,
  input wire logic source_two_undervoltage_i,
  input wire logic input_bus_node_present_i,
  input wire logic bus_overcurrent_i,
  // gate drives and converter hold
  output logic gate_drive_one_o,
  output logic gate_drive_two_o,
  output logic converter_stop_o
);
  import dpm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // sense blocks

  dpm_sense_if sense ();

  dpm_detect u_detect (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .gate_drive_one_short_i(gate_drive_one_short_i),
    .gate_drive_two_short_i(gate_drive_two_short_i),
    .sense(sense)
  );

  dpm_qual u_qual (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .source_one_present_i(source_one_present_i),
    .source_one_overvoltage_i(source_one_overvoltage_i),
    .source_one_undervoltage_i(source_one_undervoltage_i),
    .source_two_present_i(source_two_present_i),
    .source_two_overvoltage_i(source_two_overvoltage_i),
    .source_two_undervoltage_i(source_two_undervoltage_i),
    .input_bus_node_present_i(input_bus_node_present_i),
    .bus_overcurrent_i(bus_overcurrent_i),
    .sense(sense)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic is_mapped(input logic [11:0] addr);
    is_mapped = (addr == ADDR_CTRL) || (addr == ADDR_PATH) || (addr == ADDR_STAT);
  endfunction

  function automatic logic [31:0] read_word(input logic [11:0] addr, input dpm_core_t c,
                                            input logic fit1, input logic fit2,
                                            input logic v1, input logic v2);
    read_word = 32'h0000_0000;
    case (addr)
      ADDR_CTRL: begin
        read_word[CTRL_GDIS_BIT] = c.gdis;
        read_word[CTRL_BOTH_BIT] = c.both_dis;
        read_word[CTRL_HIZ_BIT] = c.hiz;
      end
      ADDR_PATH: begin
        read_word[PATH_EN1_BIT] = c.en1;
        read_word[PATH_EN2_BIT] = c.en2;
      end
      ADDR_STAT: begin
        read_word[STAT_GD1_BIT] = c.gd1;
        read_word[STAT_GD2_BIT] = c.gd2;
        read_word[STAT_FIT1_BIT] = fit1;
        read_word[STAT_FIT2_BIT] = fit2;
        read_word[STAT_CHG_BIT] = c.conv_stop;
        read_word[STAT_VALID1_BIT] = v1;
        read_word[STAT_VALID2_BIT] = v2;
      end
      default: begin
        read_word = 32'h0000_0000;
      end
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // core state

  dpm_core_t s;
  dpm_core_t n;

  logic acc;
  logic wr_take;
  logic ctrl_wr;
  logic path_wr;
  logic w1;
  logic w2;
  logic rearm;
  logic a1;
  logic a2;
  logic bad1;
  logic bad2;
  logic block;
  logic ok1;
  logic ok2;
  logic pending;

  always_comb begin
    n = s;
    acc = psel_i & penable_i;
    // a write lands on the edge where pready is sampled high
    wr_take = acc & s.pready & pwrite_i & pstrb_i[0];
    ctrl_wr = wr_take & (paddr_i == ADDR_CTRL);
    path_wr = wr_take & (paddr_i == ADDR_PATH);
    w1 = pwdata_i[PATH_EN1_BIT] & sense.fit1;
    w2 = pwdata_i[PATH_EN2_BIT] & sense.fit2;

    // apb: one wait state, read data captured with pready
    n.pready = acc & ~s.pready;
    n.pslverr = 1'b0;
    if (acc && !s.pready) begin
      n.prdata = read_word(paddr_i, s, sense.fit1, sense.fit2, sense.valid1, sense.valid2);
      n.pslverr = ~is_mapped(paddr_i);
    end

    // control word
    if (ctrl_wr) begin
      n.gdis = pwdata_i[CTRL_GDIS_BIT];
      n.both_dis = pwdata_i[CTRL_BOTH_BIT];
      n.hiz = pwdata_i[CTRL_HIZ_BIT];
    end

    // path word: host swap, with the illegal and unsafe patterns dropped
    if (path_wr) begin
      if (w1 && w2) begin
        n.en1 = s.en1;
        n.en2 = s.en2;
      end else if (!w1 && !w2 && !(sense.valid1 && sense.valid2)) begin
        n.en1 = s.en1;
        n.en2 = s.en2;
      end else begin
        n.en1 = w1;
        n.en2 = w2;
      end
    end

    // clearing the global disable re-offers every valid source
    rearm = s.gdis & ~n.gdis;
    a1 = (sense.rise1 | (rearm & sense.valid1)) & sense.fit1;
    a2 = (sense.rise2 | (rearm & sense.valid2)) & sense.fit2;
    bad1 = s.en1 & (~sense.valid1 | (sense.bus_oc & s.gd1));
    bad2 = s.en2 & (~sense.valid2 | (sense.bus_oc & s.gd2));

    // autonomous selection; a host write in the same cycle has the last word
    if (!path_wr && !n.gdis) begin
      if (!s.en1 && !s.en2) begin
        if (a1) begin
          n.en1 = 1'b1;
        end else if (a2) begin
          n.en2 = 1'b1;
        end
      end else if (bad1 && sense.valid2 && sense.fit2) begin
        n.en1 = 1'b0;
        n.en2 = 1'b1;
      end else if (bad2 && sense.valid1 && sense.fit1) begin
        n.en2 = 1'b0;
        n.en1 = 1'b1;
      end
    end
    // limitation: a lasting bus overcurrent after a swap can swap back once the drive closes

    // global disable clears both enables so the host starts over cleanly
    if (n.gdis) begin
      n.en1 = 1'b0;
      n.en2 = 1'b0;
    end

    // locks from presence detection
    if (!sense.fit1) begin
      n.en1 = 1'b0;
    end
    if (!sense.fit2) begin
      n.en2 = 1'b0;
    end
    if (sense.det_done && !sense.fit1 && !sense.fit2) begin
      n.gdis = 1'b1;
      n.en1 = 1'b0;
      n.en2 = 1'b0;
    end

    // gate drives: break before make, new pair closes only with the bus low
    block = s.gdis | s.both_dis | s.hiz;
    ok1 = sense.fit1 & sense.valid1 & ~block & s.en1;
    ok2 = sense.fit2 & sense.valid2 & ~block & s.en2;
    n.gd1 = ok1 & (s.gd1 | (~s.gd2 & ~sense.bus_present));
    n.gd2 = ok2 & (s.gd2 | (~s.gd1 & ~sense.bus_present));
    if (!ok1 && !ok2) begin
      n.gd1 = 1'b0;
      n.gd2 = 1'b0;
    end
    pending = ok1 | ok2;

    // path sequencer; the converter is held off while a pair waits to close
    case (s.st)
      ST_DETECT: begin
        n.gd1 = 1'b0;
        n.gd2 = 1'b0;
        if (sense.det_done) begin
          n.st = ST_OPEN;
        end
      end
      ST_OPEN: begin
        if (n.gd1 || n.gd2) begin
          n.st = ST_CLOSED;
        end else if (pending) begin
          n.st = ST_CHANGE;
        end
      end
      ST_CHANGE: begin
        if (n.gd1 || n.gd2) begin
          n.st = ST_CLOSED;
        end else if (!pending) begin
          n.st = ST_OPEN;
        end
      end
      ST_CLOSED: begin
        if (!n.gd1 && !n.gd2) begin
          n.st = pending ? ST_CHANGE : ST_OPEN;
        end
      end
      default: begin
        n.st = ST_OPEN;
      end
    endcase
    n.conv_stop = (n.st == ST_CHANGE);
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      s <= CORE_RST;
    end else begin
      s <= n;
    end
  end

  assign prdata_o = s.prdata;
  assign pready_o = s.pready;
  assign pslverr_o = s.pslverr;
  assign gate_drive_one_o = s.gd1;
  assign gate_drive_two_o = s.gd2;
  assign converter_stop_o = s.conv_stop;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  AST_NEVER_BOTH_CLOSED: assert property (
    !(gate_drive_one_o && gate_drive_two_o))
    else $error("both gate drives on together");

  AST_GLOBAL_DISABLE_OFF: assert property (
    s.gdis |=> !gate_drive_one_o && !gate_drive_two_o)
    else $error("gate drive on while global disable set");

  AST_ENABLE_OFF: assert property (
    !s.en1 |=> !gate_drive_one_o)
    else $error("drive one on without its enable");

  AST_CLOSE_WITH_BUS_LOW: assert property (
    $rose(gate_drive_two_o) |-> !$past(sense.bus_present) && !$past(gate_drive_one_o))
    else $error("pair two closed with bus present or pair one on");

  AST_NO_FIT_LOCK: assert property (
    sense.det_done && !sense.fit1 && !sense.fit2 |=> s.gdis && !s.en1 && !s.en2
      && !gate_drive_one_o && !gate_drive_two_o)
    else $error("unfitted mux not locked off");

  AST_PAIR_TWO_LOCK: assert property (
    sense.det_done && !sense.fit2 |=> !s.en2 ##1 !gate_drive_two_o)
    else $error("enable two set with pair two absent");

  AST_STATUS_FOLLOWS_DRIVE: assert property (
    acc && !s.pready && paddr_i == ADDR_STAT |=> pready_o
      && prdata_o[STAT_GD1_BIT] == $past(gate_drive_one_o)
      && prdata_o[STAT_GD2_BIT] == $past(gate_drive_two_o))
    else $error("path status differs from gate drive");

  AST_BOTH_WRITE_IGNORED: assert property (
    path_wr && w1 && w2 && !s.gdis && !ctrl_wr |=> s.en1 == $past(s.en1)
      && s.en2 == $past(s.en2))
    else $error("write of both enables not ignored");

  AST_PATH_ONE_PRIORITY: assert property (
    sense.rise1 && sense.rise2 && sense.fit1 && sense.fit2 && !s.en1 && !s.en2
      && !s.gdis && !wr_take |=> s.en1 && !s.en2)
    else $error("simultaneous sources did not pick path one");

  AST_AUTO_SWAP: assert property (
    s.en1 && !sense.valid1 && sense.valid2 && sense.fit2 && !s.gdis && !wr_take
      |=> s.en2 && !s.en1)
    else $error("no swap after source one failed");

  AST_APB_ONE_WAIT: assert property (
    psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
    else $error("apb answer not after one wait state");

  COV_CLOSE_ONE: cover property ($rose(gate_drive_one_o));
  COV_CHANGEOVER: cover property (gate_drive_one_o ##1 converter_stop_o [*2] ##1 gate_drive_two_o);
  COV_AUTO_SWAP: cover property (s.en1 && !sense.valid1 && sense.valid2 ##1 s.en2);
  COV_IGNORED_WRITE: cover property (path_wr && w1 && w2);

endmodule // dpm_power_mux

/* hdl/dpm_qual.sv */
// module: qualification of both switched sources and the input bus
`timescale 1ns/10ps
module dpm_qual (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // source and bus comparators
  input wire logic source_one_present_i,
  input wire logic source_one_overvoltage_i,
  input wire logic source_one_undervoltage_i,
  input wire logic source_two_present_i,
  input wire logic source_two_overvoltage_i,
  input wire logic source_two_undervoltage_i,
  input wire logic input_bus_node_present_i,
  input wire logic bus_overcurrent_i,
  // results
  dpm_sense_if.qual sense
);
  import dpm_pkg::*;

  dpm_qual_t s;
  dpm_qual_t n;

  always_comb begin
    n = s;
    n.v1 = source_one_present_i & ~source_one_overvoltage_i & ~source_one_undervoltage_i;
    n.v2 = source_two_present_i & ~source_two_overvoltage_i & ~source_two_undervoltage_i;
    n.p1 = s.v1;
    n.p2 = s.v2;
    n.bus = input_bus_node_present_i;
    n.oc = bus_overcurrent_i;
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      s <= QUAL_RST;
    end else begin
      s <= n;
    end
  end

  assign sense.valid1 = s.v1;
  assign sense.valid2 = s.v2;
  assign sense.rise1 = s.v1 & ~s.p1;
  assign sense.rise2 = s.v2 & ~s.p2;
  assign sense.bus_present = s.bus;
  assign sense.bus_oc = s.oc;
endmodule // dpm_qual

/* testbench/dpm_fet_model.sv */
// partner model: external back-to-back switch pairs and the input bus node they feed
`timescale 1ns/10ps
module dpm_fet_model (
  // clock
  input wire logic core_clk_i,
  // board fitting, sources and bus hold time
  input wire logic fitted_one_i,
  input wire logic fitted_two_i,
  input wire logic source_one_i,
  input wire logic source_two_i,
  input wire logic direct_i,
  input wire logic [3:0] decay_i,
  // device pins
  input wire logic gate_drive_one_i,
  input wire logic gate_drive_two_i,
  output logic gate_drive_one_short_o,
  output logic gate_drive_two_short_o,
  output logic input_bus_node_present_o
);
  logic [3:0] hold_q = 4'h0;
  logic feed;

  // a missing pair leaves its drive pin strapped to ground
  assign gate_drive_one_short_o = !fitted_one_i;
  assign gate_drive_two_short_o = !fitted_two_i;
  assign feed = (gate_drive_one_i & source_one_i) | (gate_drive_two_i & source_two_i) | direct_i;

  ////////////////////////////////////////////////////////////////////////////////
  // bus capacitance keeps the node up for a while after every feed is gone
  always_ff @(posedge core_clk_i) begin
    if (feed) begin
      hold_q <= decay_i;
    end else if (hold_q != 4'h0) begin
      hold_q <= hold_q - 4'h1;
    end
  end
  assign input_bus_node_present_o = feed | (hold_q != 4'h0);
endmodule // dpm_fet_model

/* testbench/dpm_power_mux_test.sv */
// testbench: register access and path selection of the power mux control
`timescale 1ns/10ps
module dpm_power_mux_test;
  import dpm_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, short1, short2, bus_present, gd1, gd2, conv_stop, err;
  logic fit1 = 1'b0, fit2 = 1'b0, direct = 1'b0, bus_oc = 1'b0;
  logic s1p = 1'b0, s1ov = 1'b0, s1uv = 1'b0, s2p = 1'b0, s2ov = 1'b0, s2uv = 1'b0;
  logic [3:0] decay = 4'h1;
  logic [31:0] rd;
  int n_fail = 0;
  int checks = 0;

  always #2.5 core_clk = ~core_clk;

  dpm_power_mux i_dut (.core_clk_i(core_clk), .resetn_i(resetn), .paddr_i(paddr),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
    .pstrb_i(4'hF), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .gate_drive_one_short_i(short1), .gate_drive_two_short_i(short2),
    .source_one_present_i(s1p), .source_one_overvoltage_i(s1ov),
    .source_one_undervoltage_i(s1uv), .source_two_present_i(s2p),
    .source_two_overvoltage_i(s2ov), .source_two_undervoltage_i(s2uv),
    .input_bus_node_present_i(bus_present), .bus_overcurrent_i(bus_oc),
    .gate_drive_one_o(gd1), .gate_drive_two_o(gd2), .converter_stop_o(conv_stop));

  dpm_fet_model i_fet (.core_clk_i(core_clk), .fitted_one_i(fit1), .fitted_two_i(fit2),
    .source_one_i(s1p), .source_two_i(s2p), .direct_i(direct), .decay_i(decay),
    .gate_drive_one_i(gd1), .gate_drive_two_i(gd2), .gate_drive_one_short_o(short1),
    .gate_drive_two_short_o(short2), .input_bus_node_present_o(bus_present));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic note(input string s);
    $display("test %s finished", s);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      close_out();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000, rd, err);
    chk(rd & m, x);
  endtask

  task automatic wait_gd(input logic e1, input logic e2);
    int n = 0;
    #1;
    while ({gd1, gd2} !== {e1, e2} && n < 40) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(32'({gd1, gd2}), 32'({e1, e2}));
    if (n >= 40) begin
      close_out();
    end
  endtask

  task automatic do_reset(input logic f1, input logic f2, input logic [3:0] dc);
    @(posedge core_clk);
    resetn <= 1'b0;
    fit1 <= f1;
    fit2 <= f2;
    decay <= dc;
    s1p <= 1'b0;
    s2p <= 1'b0;
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset(1'b0, 1'b0, 4'h1);
    s1p <= 1'b1;
    s2p <= 1'b1;
    rchk(ADDR_CTRL, 32'h0000_0001, 32'h0000_0001);
    rchk(ADDR_STAT, 32'h0000_000F, 32'h0000_0000);
    wr(ADDR_PATH, 32'h0000_0080);
    wr(ADDR_CTRL, 32'h0000_0000);
    rchk(ADDR_PATH, 32'h0000_00C0, 32'h0000_0000);
    idle(10);
    wait_gd(1'b0, 1'b0);
    note("no_pair");
    // prompt bus decay here, slow one below
    do_reset(1'b1, 1'b0, 4'h1);
    s1p <= 1'b1;
    wait_gd(1'b1, 1'b0);
    rchk(ADDR_PATH, 32'h0000_00C0, 32'h0000_0080);
    rchk(ADDR_STAT, 32'h0000_001F, 32'h0000_0005);
    wr(ADDR_PATH, 32'h0000_00C0);
    rchk(ADDR_PATH, 32'h0000_00C0, 32'h0000_0080);
    wr(ADDR_CTRL, 32'h0000_0001);
    wait_gd(1'b0, 1'b0);
    rchk(ADDR_PATH, 32'h0000_00C0, 32'h0000_0000);
    rchk(ADDR_STAT, 32'h0000_0003, 32'h0000_0000);
    direct <= 1'b1;
    repeat (6) @(posedge core_clk);
    direct <= 1'b0;
    idle(4);
    wr(ADDR_CTRL, 32'h0000_0000);
    wait_gd(1'b1, 1'b0);
    note("one_pair");
    do_reset(1'b1, 1'b1, 4'h6);
    rchk(ADDR_STAT, 32'h0000_000C, 32'h0000_000C);
    s2p <= 1'b1;
    wait_gd(1'b0, 1'b1);
    rchk(ADDR_PATH, 32'h0000_00C0, 32'h0000_0040);
    s1p <= 1'b1;
    idle(10);
    wait_gd(1'b0, 1'b1);
    rchk(ADDR_STAT, 32'h0000_007F, 32'h0000_006E);
    wr(ADDR_PATH, 32'h0000_0080);
    idle(2);
    chk(32'({gd1, gd2, conv_stop}), 32'h0000_0001);
    wait_gd(1'b1, 1'b0);
    chk(32'(conv_stop), 32'h0000_0000);
    wr(ADDR_PATH, 32'h0000_00C0);
    idle(4);
    wait_gd(1'b1, 1'b0);
    rchk(ADDR_PATH, 32'h0000_00C0, 32'h0000_0080);
    for (int i = 1; i < 3; i++) begin
      wr(ADDR_CTRL, 32'h0000_0001 << i);
      wait_gd(1'b0, 1'b0);
      wr(ADDR_CTRL, 32'h0000_0000);
      wait_gd(1'b1, 1'b0);
    end
    // undervoltage, overvoltage, then a short overcurrent burst
    for (int k = 0; k < 3; k++) begin
      @(posedge core_clk);
      s1uv <= (k == 0);
      s1ov <= (k == 1);
      bus_oc <= (k == 2);
      repeat (2) @(posedge core_clk);
      bus_oc <= 1'b0;
      wait_gd(1'b0, 1'b1);
      rchk(ADDR_PATH, 32'h0000_00C0, 32'h0000_0040);
      s1uv <= 1'b0;
      s1ov <= 1'b0;
      wr(ADDR_PATH, 32'h0000_0080);
      wait_gd(1'b1, 1'b0);
    end
    wr(ADDR_PATH, 32'h0000_0000);
    wait_gd(1'b0, 1'b0);
    wr(ADDR_PATH, 32'h0000_0080);
    wait_gd(1'b1, 1'b0);
    wr(ADDR_CTRL, 32'h0000_0001);
    wait_gd(1'b0, 1'b0);
    wr(ADDR_CTRL, 32'h0000_0000);
    wait_gd(1'b1, 1'b0);
    @(posedge core_clk);
    s2p <= 1'b0;
    idle(4);
    wr(ADDR_PATH, 32'h0000_0000);
    idle(10);
    wait_gd(1'b1, 1'b0);
    rchk(ADDR_PATH, 32'h0000_00C0, 32'h0000_0080);
    apb(1'b0, 12'h00C, 32'h0000_0000, rd, err);
    chk(32'(err), 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    note("two_pairs");
    do_reset(1'b1, 1'b1, 4'h6);
    s1p <= 1'b1;
    s2p <= 1'b1;
    wait_gd(1'b1, 1'b0);
    idle(10);
    wait_gd(1'b1, 1'b0);
    rchk(ADDR_PATH, 32'h0000_00C0, 32'h0000_0080);
    note("same_time");
    close_out();
  end
endmodule // dpm_power_mux_test
